// ===== src/spi_cfg_params.svh
// Register offsets, field positions, reset values and masks
`ifndef SPI_CFG_PARAMS_SVH
`define SPI_CFG_PARAMS_SVH

`define OFS_OPTION_CONTROL  4'h1
`define OFS_BIT_RATE        4'h2
`define OFS_CONTROL_ONE     4'h0
`define OFS_STATUS          4'h3

`define OPT_MATCH_IRQ_EN    7
`define OPT_LENGTH_SEL      6
`define OPT_FAULT_EN        4
`define OPT_SW_OE           3
`define OPT_STOP_IN_WAIT    1
`define OPT_SINGLE_WIRE     0
`define OPT_MASK            8'hdb
`define OPT_RESET           8'h00

`define BR_PRESCALE_LSB     4
`define BR_DIVIDER_LSB      0
`define BR_MASK             8'h77
`define BR_RESET            8'h00

`define C1_MASTER           4
`define C1_SEL_OE           1
`define C1_MASK             8'h12
`define C1_RESET            8'h00

`define ST_MATCH            6
`define ST_FAULT            4

`endif

// ===== src/spi_cfg_pkg.sv
// Types shared by the serial configuration block
package spi_cfg_pkg;
	typedef enum logic [1:0] {
		PIN_UNUSED,
		PIN_IN,
		PIN_OUT
	} pin_role_t;
endpackage : spi_cfg_pkg

// ===== src/rate_prescaler.sv
// Bus-clock prescaler: one enable pulse every code+1 cycles
`timescale 1ns/1ns
`include "spi_cfg_params.svh"
module rate_prescaler #(
	parameter int W = 3
) (
	input  wire logic         clk,      // Bus clock
	input  wire logic         rst_b,    // Sync reset, active low
	input  wire logic         run,      // Count enable
	input  wire logic [W-1:0] code,     // Divisor minus one
	output logic              tick      // One-cycle enable pulse
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge clk) begin
		if (!rst_b || !run) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (cnt_r >= code) begin
			cnt_r <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + W'(1);
			tick  <= 1'b0;
		end
	end
endmodule : rate_prescaler

// ===== src/rate_divider.sv
// Power-of-two divider: bit clock toggles every 2^code ticks
`timescale 1ns/1ns
`include "spi_cfg_params.svh"
module rate_divider #(
	parameter int W = 3
) (
	input  wire logic         clk,      // Bus clock
	input  wire logic         rst_b,    // Sync reset, active low
	input  wire logic         run,      // Count enable
	input  wire logic         tick_in,  // Prescaler pulse
	input  wire logic [W-1:0] code,     // Divisor is 2^(code+1)
	output logic              bit_clk,  // Divided bit clock
	output logic              bit_tick  // Pulse per full bit period
);
	logic [7:0] cnt_r;
	logic [7:0] half;

	assign half = 8'(8'h01 << code);

	always_ff @(posedge clk) begin
		if (!rst_b || !run) begin
			cnt_r    <= 8'h00;
			bit_clk  <= 1'b0;
			bit_tick <= 1'b0;
		end else if (tick_in && (cnt_r + 8'h01 >= half)) begin
			cnt_r    <= 8'h00;
			bit_clk  <= ~bit_clk;
			bit_tick <= bit_clk;
		end else begin
			if (tick_in)
				cnt_r <= cnt_r + 8'h01;
			bit_tick <= 1'b0;
		end
	end
endmodule : rate_divider

// ===== src/spi_option_and_baud_config.sv
// Option control, bit-rate registers, pin steering and rate chain
// What this block does
// - Match flag with match interrupt enable set raises interrupt; otherwise poll only.
// - Length select 0 gives 8-bit data paths; 1 gives 16-bit.
// - Master length change aborts transfer, forces idle, clears status flags.
// - As slave, fault enable ignored; select pin is active-low select input.
// - Master with fault enable 0 releases select pin to general port.
// - Master with fault enable 1 uses select pin for fault or output.
// - Select output enable 0 means fault input; 1 drives select automatically.
// - Single-wire output enable 0 disables shared driver; 1 drives it.
// - With separate pins, single-wire output enable is ignored.
// - Single-wire shared pin is master-out as master, master-in as slave.
// - Pin-control 0 uses separate data pins; 1 uses single wire.
// - Single-wire master leaves master-in unused; master-out is input or I/O.
// - Single-wire slave leaves master-out unused; master-in is input or I/O.
// - Two-pin master drives master-out, samples master-in; slave the reverse.
// - Stop-in-wait 1 stops serial clocks in wait; 0 keeps them.
// - Bit-rate register readable and writable at any time.
// - Bit-rate settings make the bit clock only in master mode.
// - Prescaler divides bus clock by code plus one, one to eight.
// - Divider divides prescaler output by two to power code plus one.
`timescale 1ns/1ns
`include "spi_cfg_params.svh"
module spi_option_and_baud_config #(
	parameter int ADDR_W = 4
) (
	input  wire logic              clk,            // Bus clock
	input  wire logic              rst_b,          // Sync reset, active low
	input  wire logic [ADDR_W-1:0] addr,           // Register address
	input  wire logic [7:0]        wdata,          // Write data
	input  wire logic              wr,             // Write strobe
	input  wire logic              rd,             // Read strobe
	output logic      [7:0]        rdata,          // Read data, next cycle
	input  wire logic              spi_enable,     // Unit enabled
	input  wire logic              wait_mode,      // Device in wait mode
	input  wire logic              match_event,    // Receive data matched
	input  wire logic              fault_event,    // Fault seen by engine
	input  wire logic              busy,           // Transfer in progress
	input  wire logic              mosi_in,        // Master-out pin level
	output logic                   mosi_out,       // Master-out pin drive
	output logic                   mosi_oe,        // Master-out pin enable
	input  wire logic              miso_in,        // Master-in pin level
	output logic                   miso_out,       // Master-in pin drive
	output logic                   miso_oe,        // Master-in pin enable
	input  wire logic              sel_in_b,       // Select pin level
	output logic                   sel_out_b,      // Select pin drive
	output logic                   sel_oe,         // Select pin enable
	output logic                   sel_port_owned, // Select pin to port
	output logic                   mosi_port_owned,// Master-out to port
	output logic                   miso_port_owned,// Master-in to port
	input  wire logic              tx_bit,         // Engine serial out
	output logic                   rx_bit,         // Serial data to engine
	output logic                   slave_selected, // Slave select active
	output logic                   fault_detect,   // Fault input asserted
	output logic                   word_16,        // 16-bit data path
	output logic                   abort_pulse,    // Abort to idle
	output logic                   unit_clk_en,    // Serial clocks run
	output logic                   bit_clk,        // Master bit clock
	output logic                   bit_tick,       // Per bit period pulse
	output logic                   match_irq       // Match interrupt
);
	// ===============================================================
	// Registers
	logic [7:0] opt_r;
	logic [7:0] br_r;
	logic [7:0] c1_r;
	logic       match_flag_r;
	logic       fault_flag_r;
	logic       match_seen_r;
	logic       fault_seen_r;
	logic [7:0] rdata_nxt;
	logic       master;
	logic       single_wire;
	logic       sw_oe;
	logic       fault_en;
	logic       sel_oe_bit;
	logic       len_change;
	logic       status_rd;
	logic       pre_tick;
	logic       rate_run;
	logic       opt_hit;
	logic       br_hit;
	logic       c1_hit;
	logic       st_hit;
	logic       opt_wr;
	logic       br_wr;
	logic       c1_wr;
	logic       st_wr;
	logic       master_abort;
	logic       match_clr;
	logic       fault_clr;
	logic [7:0] status_byte;
	logic [2:0] prescale_code;
	logic [2:0] rate_divider_code;
	spi_cfg_pkg::pin_role_t mosi_role;
	spi_cfg_pkg::pin_role_t miso_role;

	assign master      = c1_r[`C1_MASTER];
	assign sel_oe_bit  = c1_r[`C1_SEL_OE];
	assign single_wire = opt_r[`OPT_SINGLE_WIRE];
	assign sw_oe       = opt_r[`OPT_SW_OE];
	assign fault_en    = opt_r[`OPT_FAULT_EN];
	assign word_16     = opt_r[`OPT_LENGTH_SEL];
	assign status_rd   = rd && st_hit;

	// ===============================================================
	// Address decode
	always_comb begin
		opt_hit = 1'b0;
		br_hit  = 1'b0;
		c1_hit  = 1'b0;
		st_hit  = 1'b0;
		if (addr == ADDR_W'(`OFS_OPTION_CONTROL))
			opt_hit = 1'b1;
		else if (addr == ADDR_W'(`OFS_BIT_RATE))
			br_hit = 1'b1;
		else if (addr == ADDR_W'(`OFS_CONTROL_ONE))
			c1_hit = 1'b1;
		else if (addr == ADDR_W'(`OFS_STATUS))
			st_hit = 1'b1;
	end

	assign opt_wr = wr && opt_hit;
	assign br_wr  = wr && br_hit;
	assign c1_wr  = wr && c1_hit;
	assign st_wr  = wr && st_hit;

	assign len_change = opt_wr
		&& (wdata[`OPT_LENGTH_SEL] != opt_r[`OPT_LENGTH_SEL]);
	assign master_abort = len_change && master;
	assign match_clr    = st_wr && match_seen_r && wdata[`ST_MATCH];
	assign fault_clr    = c1_wr && fault_seen_r;

	// ===============================================================
	// Register file
	always_ff @(posedge clk) begin
		if (!rst_b)
			opt_r <= `OPT_RESET;
		else if (opt_wr)
			opt_r <= wdata & `OPT_MASK;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			br_r <= `BR_RESET;
		else if (br_wr)
			br_r <= wdata & `BR_MASK;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			c1_r <= `C1_RESET;
		else if (c1_wr)
			c1_r <= wdata & `C1_MASK;
	end

	// ===============================================================
	// Abort on length change in master mode
	always_ff @(posedge clk) begin
		if (!rst_b)
			abort_pulse <= 1'b0;
		else
			abort_pulse <= master_abort;
	end

	// ===============================================================
	// Status flags: clear after a status read, match by write-one to status, fault by any control-one write; set wins
	always_ff @(posedge clk) begin
		if (!rst_b)
			match_seen_r <= 1'b0;
		else if (status_rd && match_flag_r)
			match_seen_r <= 1'b1;
		else if (!match_flag_r)
			match_seen_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			match_flag_r <= 1'b0;
		else if (match_event && spi_enable)
			match_flag_r <= 1'b1;
		else if (master_abort)
			match_flag_r <= 1'b0;
		else if (match_clr)
			match_flag_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			fault_seen_r <= 1'b0;
		else if (status_rd && fault_flag_r)
			fault_seen_r <= 1'b1;
		else if (!fault_flag_r)
			fault_seen_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			fault_flag_r <= 1'b0;
		else if ((fault_event || fault_detect) && spi_enable)
			fault_flag_r <= 1'b1;
		else if (master_abort)
			fault_flag_r <= 1'b0;
		else if (fault_clr)
			fault_flag_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			match_irq <= 1'b0;
		else
			match_irq <= match_flag_r && opt_r[`OPT_MATCH_IRQ_EN];
	end

	// ===============================================================
	// Read port
	always_comb begin
		status_byte = 8'h00;
		status_byte[`ST_MATCH] = match_flag_r;
		status_byte[`ST_FAULT] = fault_flag_r;
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (opt_hit)
			rdata_nxt = opt_r;
		else if (br_hit)
			rdata_nxt = br_r;
		else if (c1_hit)
			rdata_nxt = c1_r;
		else if (st_hit)
			rdata_nxt = status_byte;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			rdata <= 8'h00;
		else if (rd)
			rdata <= rdata_nxt;
		else
			rdata <= 8'h00;
	end

	// ===============================================================
	// Select pin function
	always_comb begin
		sel_port_owned = 1'b0;
		sel_oe         = 1'b0;
		slave_selected = 1'b0;
		fault_detect   = 1'b0;
		if (!spi_enable)
			sel_port_owned = 1'b1;
		else if (!master)
			slave_selected = !sel_in_b;
		else if (!fault_en)
			sel_port_owned = 1'b1;
		else if (!sel_oe_bit)
			fault_detect = !sel_in_b;
		else
			sel_oe = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			sel_out_b <= 1'b1;
		else
			sel_out_b <= !(master && busy);
	end

	// ===============================================================
	// Data pin roles
	always_comb begin
		mosi_role = spi_cfg_pkg::PIN_UNUSED;
		miso_role = spi_cfg_pkg::PIN_UNUSED;
		if (!single_wire) begin
			mosi_role = master ? spi_cfg_pkg::PIN_OUT
				: spi_cfg_pkg::PIN_IN;
			miso_role = master ? spi_cfg_pkg::PIN_IN
				: spi_cfg_pkg::PIN_OUT;
		end else if (master)
			mosi_role = sw_oe ? spi_cfg_pkg::PIN_OUT
				: spi_cfg_pkg::PIN_IN;
		else
			miso_role = sw_oe ? spi_cfg_pkg::PIN_OUT
				: spi_cfg_pkg::PIN_IN;
	end

	always_comb begin
		mosi_oe = spi_enable && mosi_role == spi_cfg_pkg::PIN_OUT;
		miso_oe = spi_enable && miso_role == spi_cfg_pkg::PIN_OUT;
		mosi_port_owned = !spi_enable
			|| mosi_role == spi_cfg_pkg::PIN_UNUSED;
		miso_port_owned = !spi_enable
			|| miso_role == spi_cfg_pkg::PIN_UNUSED;
	end

	// Shared pin in output mode reads back its own level
	always_comb begin
		case ({single_wire, master})
			2'b00:   rx_bit = mosi_in;
			2'b01:   rx_bit = miso_in;
			2'b10:   rx_bit = miso_in;
			default: rx_bit = mosi_in;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			mosi_out <= 1'b0;
		else
			mosi_out <= tx_bit;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			miso_out <= 1'b0;
		else
			miso_out <= tx_bit;
	end

	// ===============================================================
	// Clock gating
	assign unit_clk_en = spi_enable
		&& !(wait_mode && opt_r[`OPT_STOP_IN_WAIT]);
	assign rate_run = unit_clk_en && master && !abort_pulse;

	// ===============================================================
	// Rate chain
	assign prescale_code     = br_r[`BR_PRESCALE_LSB +: 3];
	assign rate_divider_code = br_r[`BR_DIVIDER_LSB +: 3];

	rate_prescaler #(.W(3)) u_pre (
		.clk   (clk),
		.rst_b (rst_b),
		.run   (rate_run),
		.code  (prescale_code),
		.tick  (pre_tick)
	);

	rate_divider #(.W(3)) u_div (
		.clk      (clk),
		.rst_b    (rst_b),
		.run      (rate_run),
		.tick_in  (pre_tick),
		.code     (rate_divider_code),
		.bit_clk  (bit_clk),
		.bit_tick (bit_tick)
	);
endmodule : spi_option_and_baud_config

// ===== sim/spi_cfg_props.sv
// Port checker for the option and bit-rate configuration block
`timescale 1ns/1ns
module spi_cfg_props (
	input wire logic       clk,            // Bus clock
	input wire logic       rst_b,          // Sync reset, active low
	input wire logic       wr,             // Write strobe
	input wire logic       rd,             // Read strobe
	input wire logic [7:0] rdata,          // Read data
	input wire logic       spi_enable,     // Unit enabled
	input wire logic       wait_mode,      // Wait mode
	input wire logic       busy,           // Transfer running
	input wire logic       sel_in_b,       // Select pin level
	input wire logic       sel_out_b,      // Select pin drive
	input wire logic       mosi_oe,        // Master-out enable
	input wire logic       miso_oe,        // Master-in enable
	input wire logic       slave_selected, // Selected as slave
	input wire logic       word_16,        // 16-bit path
	input wire logic       abort_pulse,    // Abort to idle
	input wire logic       unit_clk_en     // Serial clocks run
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ==========
	// Abort pulse
	sequence abort_s;
		abort_pulse ##1 (!abort_pulse || $past(wr));
	endsequence
	abort_single_a: assert property (abort_pulse |-> abort_s)
		else $error("abort pulse longer than one cycle");
	abort_cause_a: assert property (
		abort_pulse |-> $past(wr) || $past(wr, 2))
		else $error("abort without a register write");
	// ==========
	// Registers and pins
	length_stable_a: assert property (!$past(wr) |-> $stable(word_16))
		else $error("length select moved without a write");
	rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	one_driver_a: assert property (!(mosi_oe && miso_oe))
		else $error("both data pins driven");
	sel_slave_a: assert property (slave_selected |-> !sel_in_b)
		else $error("selected while select pin high");
	sel_busy_a: assert property (!sel_out_b |-> $past(busy))
		else $error("select driven low while idle");
	clk_gate_a: assert property (!spi_enable |-> !unit_clk_en)
		else $error("clocks run while disabled");
	clk_run_a: assert property (
		spi_enable && !wait_mode |-> unit_clk_en)
		else $error("clocks stopped outside wait");
endmodule : spi_cfg_props

bind spi_option_and_baud_config spi_cfg_props u_props (.clk, .rst_b, .wr,
	.rd, .rdata, .spi_enable, .wait_mode, .busy, .sel_in_b, .sel_out_b,
	.mosi_oe, .miso_oe, .slave_selected, .word_16, .abort_pulse,
	.unit_clk_en);

// ===== sim/spi_far_end.sv
// Far-side serial device: drives whichever pins the block leaves free
`timescale 1ns/1ns
module spi_far_end (
	input  wire logic clk,       // Bus clock
	input  wire logic mosi_out,  // Block master-out drive
	input  wire logic mosi_oe,   // Block master-out enable
	input  wire logic miso_out,  // Block master-in drive
	input  wire logic miso_oe,   // Block master-in enable
	input  wire logic sel_out_b, // Block select drive
	input  wire logic sel_oe,    // Block select enable
	input  wire logic far_on,    // Far end drives free pins
	input  wire logic far_bit,   // Far data value
	input  wire logic far_sel_b, // Far select, active low
	output logic      mosi_in,   // Master-out pin level
	output logic      miso_in,   // Master-in pin level
	output logic      sel_in_b   // Select pin level
);
	logic alt_r = 1'b0;
	// Released pins show a changing pattern
	always @(posedge clk) begin
		alt_r <= ~alt_r;
	end
	assign mosi_in  = mosi_oe ? mosi_out : (far_on ? far_bit : alt_r);
	assign miso_in  = miso_oe ? miso_out : (far_on ? far_bit : alt_r);
	assign sel_in_b = sel_oe ? sel_out_b : (far_on ? far_sel_b : alt_r);
endmodule : spi_far_end

// ===== sim/spi_option_and_baud_config_tb.sv
// Self-checking bench for the option and bit-rate configuration block
`timescale 1ns/1ns
`include "spi_cfg_params.svh"
module spi_option_and_baud_config_tb;
	logic       clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, v;
	logic       spi_enable = 1'b1, wait_mode = 1'b0, match_event = 1'b0;
	logic       fault_event = 1'b0, busy = 1'b0, tx_bit = 1'b0;
	logic       far_on = 1'b0, far_bit = 1'b0, far_sel_b = 1'b0;
	logic       mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
	logic       sel_in_b, sel_out_b, sel_oe, sel_port_owned, rx_bit;
	logic       mosi_port_owned, miso_port_owned, slave_selected;
	logic       fault_detect, word_16, abort_pulse, unit_clk_en;
	logic       bit_clk, bit_tick, match_irq;
	logic [4:0] c;
	logic [2:0] p, d;
	int         seed = 9632, mismatches = 0, total_checks = 0;
	int         aborts = 0, n;

	spi_option_and_baud_config uut (.*);
	spi_far_end far (.*);

	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (abort_pulse === 1'b1)
			aborts++;
	end
	// ==========
	// Helpers
	task chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wreg(input logic [3:0] a, input logic [7:0] dv);
		@(posedge clk);
		addr  <= a;
		wdata <= dv;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task rreg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk({8'h00, rdata}, {8'h00, e});
	endtask : rreg
	task tickwait(output int k);
		k = 1;
		@(posedge clk);
		while (bit_tick !== 1'b1 && k < 5000) begin
			@(posedge clk);
			k++;
		end
	endtask : tickwait
	// Pin roles: master, single wire, wire drive, fault enable, select out
	function automatic logic [7:0] pins(input logic [4:0] s);
		logic m, o;
		m = s[0];
		o = !s[1] | s[2];
		return {m & o, !m & o, !m & s[1], m & s[1], m & s[3] & s[4],
			m & !s[3], m & s[3] & !s[4], !m};
	endfunction : pins
	function automatic int period(input logic [2:0] pp, input logic [2:0] dd);
		return (int'(pp) + 1) << (int'(dd) + 1);
	endfunction : period
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	initial begin
		#1000000;
		mismatches++;
		give_verdict;
	end
	// ==========
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rreg(4'h1, 8'h00);
		rreg(4'h2, 8'h00);
		for (int k = 0; k < 8; k++) begin
			v = 8'($random(seed));
			wreg(4'h1 + 4'(k[0]), v);
			rreg(4'h1 + 4'(k[0]), v & (k[0] ? `BR_MASK : `OPT_MASK));
		end
		wreg(4'h9, 8'hff);
		rreg(4'h9, 8'h00);
		far_on <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			c = 5'(i);
			wreg(4'h0, {3'h0, c[0], 2'h0, c[4], 1'b0});
			wreg(4'h1, {3'h0, c[3], c[2], 2'h0, c[1]});
			far_bit <= 1'($random(seed));
			tx_bit  <= 1'($random(seed));
			far_sel_b <= 1'($random(seed));
			@(posedge clk);
			#1 chk({mosi_oe, miso_oe, mosi_port_owned, miso_port_owned, sel_oe,
				sel_port_owned, fault_detect, slave_selected},
				pins(c) & {6'h3f, {2{!far_sel_b}}});
			if (!(c[1] && c[2]))
				chk(rx_bit, far_bit);
			else
				chk(rx_bit, tx_bit);
		end
		busy <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(sel_out_b, 1'b0);
		busy   <= 1'b0;
		far_on <= 1'b0;
		wreg(4'h1, 8'h40);
		rreg(4'h3, 8'h00);
		chk(aborts, 1);
		chk(word_16, 1'b1);
		wreg(4'h1, 8'hc0);
		match_event <= 1'b1;
		@(posedge clk);
		match_event <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(match_irq, 1'b1);
		rreg(4'h3, 8'h40);
		wreg(4'h1, 8'h40);
		repeat (2) @(posedge clk);
		#1 chk(match_irq, 1'b0);
		wreg(4'h1, 8'h00);
		rreg(4'h3, 8'h00);
		chk({aborts[14:0], word_16}, 16'h0004);
		wreg(4'h0, 8'h00);
		wreg(4'h1, 8'h40);
		rreg(4'h3, 8'h00);
		chk({aborts[14:0], word_16}, 16'h0005);
		match_event <= 1'b1;
		@(posedge clk);
		match_event <= 1'b0;
		rreg(4'h3, 8'h40);
		wreg(4'h3, 8'h40);
		rreg(4'h3, 8'h00);
		for (int j = 0; j < 8; j++) begin
			wreg(4'h1, {6'h00, j[1], 1'b0});
			wait_mode  <= j[0];
			spi_enable <= !j[2];
			@(posedge clk);
			#1 chk(unit_clk_en, !j[2] && !(j[0] && j[1]));
		end
		spi_enable <= 1'b1;
		wait_mode  <= 1'b0;
		wreg(4'h0, 8'h10);
		for (int k = 0; k < 6; k++) begin
			{p, d} = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : 6'($random(seed));
			wreg(4'h2, {1'b0, p, 1'b0, d});
			tickwait(n);
			tickwait(n);
			chk(16'(n), 16'(period(p, d)));
		end
		wreg(4'h0, 8'h00);
		repeat (3) @(posedge clk);
		tickwait(n);
		chk(16'(n), 16'd5000);
		chk(bit_clk, 1'b0);
		give_verdict;
	end
endmodule : spi_option_and_baud_config_tb
